// >>> decoder_consts.svh
/*
 Register offsets, field positions, reset values and timing counts for the
 instruction decoder. Assumes inclusion by the decoder module only; the package does not include it.
*/
`ifndef DECODER_CONSTS_SVH
`define DECODER_CONSTS_SVH
// Register byte addresses on the register bus
`define ADDR_INSTR 8'h00
`define ADDR_OPERAND 8'h04
`define ADDR_ACC 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_RESULT 8'h10
`define ADDR_PC 8'h14
`define ADDR_CTRL 8'h18
`define ADDR_PINS 8'h1C
// Status register bit positions
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_PD 3
`define ST_TO 4
`define ST_BUSY 5
`define ST_STANDBY 6
`define ST_GIE 7
// Control register bit position
`define CTRL_PRESC 0
// Oscillator periods in one instruction cycle
`define QUARTERS 4
`define QUARTER_LAST 2'h3
// Special file addresses
`define TMR_ADDR 7'h01
`define PORT_LO 7'h05
`define PORT_HI 7'h07
// Fixed control words, low byte of 00 0000 xxxx xxxx
`define LOW_RETURN 8'h08
`define LOW_RETFIE 8'h09
`define LOW_SLEEP 8'h63
`define LOW_CLRWDT 8'h64
// Reset values
`define RST_TO 1'b1
`define RST_PD 1'b1
`define RST_ACC 8'h00
`endif

// >>> decoder_pkg.sv
/*
 Types shared by the instruction decoder: sequencing states and the result
 of decoding one instruction word. Assumes nothing of its surroundings.
*/
package decoder_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} state_type;
    typedef struct packed {
        logic [7:0] value;
        logic [6:0] dst;
        logic wr_acc;
        logic wr_file;
        logic upd_c;
        logic upd_dc;
        logic upd_z;
        logic c;
        logic dc;
        logic skip;
        logic pc_load;
        logic push;
        logic pop;
        logic retfie;
        logic sleep;
        logic clrwdt;
    } result_type;
endpackage

// >>> insn_decoder.sv
/*
 Decoder and executor for 14-bit instruction words of an 8-bit accumulator core,
 reached over APB. Assumes one 50 MHz clock, synchronous active-low reset and an
 APB master in the same clock domain that supplies file operands and pin levels.
*/
// Added by the designer: the APB register port and the address map.
// Notes on behaviour
// RULE1 - Byte ops: 00, opcode, dest, 7-bit file
// RULE2 - Dest 0 writes accumulator, 1 writes file
// RULE3 - Bit ops: 01, op, position, file; clear/set
// RULE4 - Bit test skips when selected bit clear
// RULE5 - Bit test skips when selected bit set
// RULE6 - OR, XOR, AND with file update zero
// RULE7 - Rotates through carry change carry only
// RULE8 - Inc/dec skip on zero, no flags
// RULE9 - Don't-care bits accepted either value
// RULE10 - Literal OR and XOR update zero
// RULE11 - Return with literal loads accumulator, two cycles
// RULE12 - Literal minus accumulator updates C, DC, Z
// RULE13 - Standby word sets timeout, clears powerdown
// RULE14 - Plain instructions take one cycle
// RULE15 - Skips and jumps add a NOP cycle
// RULE16 - One cycle is four clock periods
// RULE17 - Port operands come from pin levels
// RULE18 - Timer count write clears assigned prescaler
// RULE19 - Eight-bit data literal, eleven-bit jump literal
// RULE20 - Remaining encodings with documented cycles, flags
// RULE21 - Undefined words behave as no-operation
`timescale 1ns/1ns
`include "decoder_consts.svh"
module insn_decoder
#(
    parameter int PC_WIDTH = 11,
    parameter int STACK_DEPTH = 8
)
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic TMR_PRESCALE_CLEAR,
    output logic WDT_CLEAR,
    output logic STANDBY
);
    import decoder_pkg::*;

    localparam int SPW = $clog2(STACK_DEPTH);

    state_type state_reg;
    logic [1:0] quarter_reg;
    logic [13:0] ir_reg;
    logic [7:0] file_data_reg;
    logic [7:0] pins_reg;
    logic [7:0] acc_reg;
    logic c_reg, dc_reg, z_reg, to_reg, pd_reg, gie_reg;
    logic presc_assigned_reg;
    logic [PC_WIDTH-1:0] pc_reg;
    logic [PC_WIDTH-1:0] stack_mem [STACK_DEPTH];
    logic [SPW-1:0] sp_reg;
    result_type last_reg;
    result_type res;
    logic [7:0] opnd;
    logic [7:0] logic_val;
    logic [9:0] sum;
    logic commit, start, wr_en, two_cycle;
    logic [31:0] rd_mux;

    // Sum with carry out and nibble carry: {c, dc, sum}
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        return {hi[4], lo[4], hi[3:0], lo[3:0]};
    endfunction

    // Mapped register addresses
    function automatic logic addr_ok(input logic [7:0] a);
        return a == `ADDR_INSTR || a == `ADDR_OPERAND || a == `ADDR_ACC || a == `ADDR_STATUS ||
            a == `ADDR_RESULT || a == `ADDR_PC || a == `ADDR_CTRL || a == `ADDR_PINS;
    endfunction

    assign commit = state_reg == ST_EXEC && quarter_reg == `QUARTER_LAST;
    assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
    assign start = wr_en && PADDR == `ADDR_INSTR && state_reg == ST_IDLE;
    // Port addresses read the sampled pins, not the output latch
    assign opnd = (ir_reg[6:0] >= `PORT_LO && ir_reg[6:0] <= `PORT_HI) ? pins_reg : file_data_reg; // [RULE17]
    assign two_cycle = res.skip || res.pc_load || res.pop; // [RULE15]

    // Decode the held instruction word into one result
    always_comb
    begin
        res = '0;
        res.dst = ir_reg[6:0]; // [RULE1]
        res.value = opnd;
        logic_val = 8'h00;
        sum = 10'h000;
        unique case (ir_reg[13:12])
            2'b00:
            begin
                res.wr_file = ir_reg[7]; // [RULE2]
                res.wr_acc = !ir_reg[7];
                res.upd_z = 1'b1;
                unique case (ir_reg[11:8])
                    4'h0:
                    begin
                        // Move accumulator to file, or fixed control words; others are NOP [RULE9] [RULE21]
                        res.upd_z = 1'b0;
                        res.wr_acc = 1'b0;
                        res.value = acc_reg;
                        res.pop = !ir_reg[7] && (ir_reg[7:0] == `LOW_RETURN || ir_reg[7:0] == `LOW_RETFIE); // [RULE20]
                        res.retfie = ir_reg[7:0] == `LOW_RETFIE;
                        res.sleep = ir_reg[7:0] == `LOW_SLEEP; // [RULE13]
                        res.clrwdt = ir_reg[7:0] == `LOW_CLRWDT;
                    end
                    4'h1: res.value = 8'h00;
                    4'h2:
                    begin
                        sum = add8(opnd, ~acc_reg, 1'b1);
                        {res.c, res.dc, res.value} = sum;
                        res.upd_c = 1'b1;
                        res.upd_dc = 1'b1;
                    end
                    4'h3: res.value = opnd - 8'h01;
                    4'h4: res.value = acc_reg | opnd; // [RULE6]
                    4'h5: res.value = acc_reg & opnd; // [RULE6]
                    4'h6: res.value = acc_reg ^ opnd; // [RULE6]
                    4'h7:
                    begin
                        sum = add8(opnd, acc_reg, 1'b0);
                        {res.c, res.dc, res.value} = sum;
                        res.upd_c = 1'b1;
                        res.upd_dc = 1'b1;
                    end
                    4'h8: res.value = opnd;
                    4'h9: res.value = ~opnd;
                    4'hA: res.value = opnd + 8'h01;
                    4'hB:
                    begin
                        res.value = opnd - 8'h01; // [RULE8]
                        res.upd_z = 1'b0;
                        res.skip = res.value == 8'h00;
                    end
                    4'hC:
                    begin
                        res.value = {c_reg, opnd[7:1]}; // [RULE7]
                        res.c = opnd[0];
                        res.upd_c = 1'b1;
                        res.upd_z = 1'b0;
                    end
                    4'hD:
                    begin
                        res.value = {opnd[6:0], c_reg}; // [RULE7]
                        res.c = opnd[7];
                        res.upd_c = 1'b1;
                        res.upd_z = 1'b0;
                    end
                    4'hE:
                    begin
                        res.value = {opnd[3:0], opnd[7:4]};
                        res.upd_z = 1'b0;
                    end
                    4'hF:
                    begin
                        res.value = opnd + 8'h01; // [RULE8]
                        res.upd_z = 1'b0;
                        res.skip = res.value == 8'h00;
                    end
                endcase
            end
            2'b01:
            begin
                // Bit clear, set and tests; no flag changes [RULE3]
                logic_val = 8'h01 << ir_reg[9:7];
                unique case (ir_reg[11:10])
                    2'b00:
                    begin
                        res.value = opnd & ~logic_val;
                        res.wr_file = 1'b1;
                    end
                    2'b01:
                    begin
                        res.value = opnd | logic_val;
                        res.wr_file = 1'b1;
                    end
                    2'b10: res.skip = (opnd & logic_val) == 8'h00; // [RULE4]
                    2'b11: res.skip = (opnd & logic_val) != 8'h00; // [RULE5]
                endcase
            end
            2'b10:
            begin
                // Call pushes, jump does not; eleven-bit target [RULE19] [RULE20]
                res.pc_load = 1'b1;
                res.push = !ir_reg[11];
            end
            2'b11:
            begin
                // Eight-bit literal operations [RULE19] [RULE9]
                res.wr_acc = 1'b1;
                res.upd_z = 1'b1;
                unique casez (ir_reg[11:8])
                    4'b00??:
                    begin
                        res.value = ir_reg[7:0];
                        res.upd_z = 1'b0;
                    end
                    4'b01??:
                    begin
                        res.value = ir_reg[7:0]; // [RULE11]
                        res.upd_z = 1'b0;
                        res.pop = 1'b1;
                    end
                    4'b1000: res.value = acc_reg | ir_reg[7:0]; // [RULE10]
                    4'b1001: res.value = acc_reg & ir_reg[7:0];
                    4'b1010: res.value = acc_reg ^ ir_reg[7:0]; // [RULE10]
                    4'b1011:
                    begin
                        res.wr_acc = 1'b0; // [RULE21]
                        res.upd_z = 1'b0;
                    end
                    4'b110?:
                    begin
                        sum = add8(ir_reg[7:0], ~acc_reg, 1'b1); // [RULE12]
                        {res.c, res.dc, res.value} = sum;
                        res.upd_c = 1'b1;
                        res.upd_dc = 1'b1;
                    end
                    4'b111?:
                    begin
                        sum = add8(ir_reg[7:0], acc_reg, 1'b0);
                        {res.c, res.dc, res.value} = sum;
                        res.upd_c = 1'b1;
                        res.upd_dc = 1'b1;
                    end
                endcase
            end
        endcase
    end

    // Sequencer: four clocks per instruction cycle, optional NOP cycle
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            state_reg <= ST_IDLE;
            quarter_reg <= 2'h0;
        end
        else
        begin
            quarter_reg <= (state_reg == ST_IDLE) ? 2'h0 : quarter_reg + 2'h1; // [RULE16]
            unique case (state_reg)
                ST_IDLE: if (start) state_reg <= ST_EXEC;
                ST_EXEC: if (commit) state_reg <= two_cycle ? ST_NOP : ST_IDLE; // [RULE14] [RULE15]
                ST_NOP: if (quarter_reg == `QUARTER_LAST) state_reg <= ST_IDLE;
            endcase
        end
    end

    // Accumulator and status flags
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            acc_reg <= `RST_ACC;
            {c_reg, dc_reg, z_reg, gie_reg} <= 4'h0;
            to_reg <= `RST_TO;
            pd_reg <= `RST_PD;
        end
        else if (commit)
        begin
            if (res.wr_acc) acc_reg <= res.value; // [RULE2]
            if (res.upd_c) c_reg <= res.c; // [RULE7] [RULE12]
            if (res.upd_dc) dc_reg <= res.dc;
            if (res.upd_z) z_reg <= res.value == 8'h00; // [RULE6] [RULE10]
            if (res.retfie) gie_reg <= 1'b1;
            if (res.sleep || res.clrwdt) to_reg <= 1'b1; // [RULE13]
            if (res.sleep || res.clrwdt) pd_reg <= res.clrwdt;
        end
        else if (wr_en && state_reg == ST_IDLE && PADDR == `ADDR_ACC)
            acc_reg <= PWDATA[7:0];
    end

    // Program counter and return stack
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            pc_reg <= '0;
            sp_reg <= '0;
        end
        else if (commit)
        begin
            if (res.pc_load) pc_reg <= ir_reg[PC_WIDTH-1:0]; // [RULE19]
            else if (res.pop) pc_reg <= stack_mem[sp_reg - SPW'(1)]; // [RULE11]
            else pc_reg <= pc_reg + (res.skip ? PC_WIDTH'(2) : PC_WIDTH'(1));
            if (res.push)
            begin
                stack_mem[sp_reg] <= pc_reg + PC_WIDTH'(1);
                sp_reg <= sp_reg + SPW'(1);
            end
            else if (res.pop) sp_reg <= sp_reg - SPW'(1);
        end
    end

    // Side effects toward timer, watchdog and power control
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            TMR_PRESCALE_CLEAR <= 1'b0;
            WDT_CLEAR <= 1'b0;
            STANDBY <= 1'b0;
            last_reg <= '0;
        end
        else
        begin
            TMR_PRESCALE_CLEAR <= commit && res.wr_file && res.dst == `TMR_ADDR && presc_assigned_reg; // [RULE18]
            WDT_CLEAR <= commit && (res.clrwdt || res.sleep);
            if (commit && res.sleep) STANDBY <= 1'b1; // [RULE13]
            else if (start) STANDBY <= 1'b0;
            if (commit) last_reg <= res;
        end
    end

    // Software-written registers
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            ir_reg <= 14'h0000;
            file_data_reg <= 8'h00;
            pins_reg <= 8'h00;
            presc_assigned_reg <= 1'b0;
        end
        else
        begin
            if (start) ir_reg <= PWDATA[13:0];
            if (wr_en && state_reg == ST_IDLE && PADDR == `ADDR_OPERAND) file_data_reg <= PWDATA[7:0];
            if (wr_en && PADDR == `ADDR_PINS) pins_reg <= PWDATA[7:0];
            if (wr_en && PADDR == `ADDR_CTRL) presc_assigned_reg <= PWDATA[`CTRL_PRESC];
        end
    end

    // Read multiplexer
    always_comb
    begin
        rd_mux = 32'h00000000;
        unique case (PADDR)
            `ADDR_INSTR: rd_mux = {18'h00000, ir_reg};
            `ADDR_OPERAND: rd_mux = {24'h000000, file_data_reg};
            `ADDR_ACC: rd_mux = {24'h000000, acc_reg};
            `ADDR_STATUS: rd_mux = {24'h000000, gie_reg, STANDBY, state_reg != ST_IDLE, to_reg, pd_reg,
                z_reg, dc_reg, c_reg};
            `ADDR_RESULT: rd_mux = {15'h0000, last_reg.wr_acc, last_reg.wr_file, last_reg.dst, last_reg.value};
            `ADDR_PC: rd_mux = {{(32-PC_WIDTH){1'b0}}, pc_reg};
            `ADDR_CTRL: rd_mux = {31'h00000000, presc_assigned_reg};
            `ADDR_PINS: rd_mux = {24'h000000, pins_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // APB slave: ready in the first access cycle, data latched at setup
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end
        else
        begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !addr_ok(PADDR);
            if (PSEL && !PENABLE) PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    sequence s_exec4;
        (state_reg == ST_EXEC)[*4];
    endsequence
    sequence s_nop4;
        (state_reg == ST_NOP)[*4] ##1 (state_reg == ST_IDLE);
    endsequence

    property p_cycle_four;
        start |=> s_exec4 ##1 (state_reg != ST_EXEC);
    endproperty
    a_cycle_four: assert property (p_cycle_four) else $error("instruction cycle not four clocks"); // [RULE16]
    property p_single;
        commit && !res.skip && !res.pc_load && !res.pop |=> state_reg == ST_IDLE;
    endproperty
    a_single: assert property (p_single) else $error("plain instruction took extra cycle"); // [RULE14]
    property p_double;
        commit && (res.pc_load || res.pop) |=> s_nop4;
    endproperty
    a_double: assert property (p_double) else $error("branch lacked NOP cycle"); // [RULE15]
    // Destination select decides both the write strobe and what the accumulator holds afterwards
    property p_dest;
        commit && ir_reg[13:12] == 2'b00 && ir_reg[11:8] != 4'h0 |-> (res.wr_acc == !ir_reg[7]) ##1
            (acc_reg == ($past(ir_reg[7]) ? $past(acc_reg) : $past(res.value)));
    endproperty
    a_dest: assert property (p_dest) else $error("destination select wrong"); // [RULE2]
    property p_logic_z;
        commit && ir_reg[13:10] == 4'b0001 && ir_reg[9:8] != 2'b11 |=>
            z_reg == ($past(res.value) == 8'h00) && $stable(c_reg) && $stable(dc_reg);
    endproperty
    a_logic_z: assert property (p_logic_z) else $error("logic op flag update wrong"); // [RULE6]
    property p_rotate;
        commit && ir_reg[13:9] == 5'b00110 |=> $stable(z_reg) && $stable(dc_reg) && c_reg == $past(res.c);
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate changed wrong flags"); // [RULE7]
    property p_incdec;
        commit && ir_reg[13:12] == 2'b00 && ir_reg[11] && ir_reg[9:8] == 2'b11 && res.value == 8'h00 |=> s_nop4;
    endproperty
    a_incdec: assert property (p_incdec) else $error("zero result did not skip"); // [RULE8]
    property p_test_clear;
        commit && ir_reg[13:10] == 4'b0110 && opnd[ir_reg[9:7]] == 1'b0 |=> state_reg == ST_NOP;
    endproperty
    a_test_clear: assert property (p_test_clear) else $error("clear-bit test did not skip"); // [RULE4]
    property p_test_set;
        commit && ir_reg[13:10] == 4'b0111 |=> (state_reg == ST_NOP) == $past(opnd[ir_reg[9:7]]);
    endproperty
    a_test_set: assert property (p_test_set) else $error("set-bit test skip wrong"); // [RULE5]
    property p_presc;
        commit && res.wr_file && res.dst == `TMR_ADDR && presc_assigned_reg |=>
            TMR_PRESCALE_CLEAR ##1 !TMR_PRESCALE_CLEAR;
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler not cleared"); // [RULE18]
    property p_sleep;
        commit && ir_reg == {6'h00, `LOW_SLEEP} |=> STANDBY && to_reg && !pd_reg && state_reg == ST_IDLE;
    endproperty
    a_sleep: assert property (p_sleep) else $error("standby entry wrong"); // [RULE13]
endmodule

// >>> prog_mem.sv
/*
 Program memory and fetch stage model: hands the bench one instruction word
 and its file operand per index. Assumes the bench steps the index.
*/
`timescale 1ns/1ns
module prog_mem
(
    input wire logic [4:0] addr,
    output logic [13:0] word,
    output logic [7:0] operand
);
    // Words use both values in don't-care positions
    localparam logic [13:0] WORDS [0:23] = '{14'h04A0, 14'h057F, 14'h0605, 14'h0DA1, 14'h0C22, 14'h0BA3,
        14'h0F24, 14'h13A5, 14'h1426, 14'h19A7, 14'h1C28, 14'h1C28, 14'h380A, 14'h3A5A, 14'h3D10, 14'h3377,
        14'h3499, 14'h0060, 14'h0001, 14'h3E01, 14'h0064, 14'h2923, 14'h0063, 14'h1401};
    localparam logic [7:0] OPNDS [0:23] = '{8'hF0, 8'h0F, 8'hFF, 8'h81, 8'h02, 8'h01, 8'h10, 8'hFF,
        8'h00, 8'hF7, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00};
    // Fetch returns the addressed word and its operand
    assign word = WORDS[addr];
    assign operand = OPNDS[addr];
endmodule

// >>> tb_top.sv
/*
 Self-checking bench for the instruction decoder: runs a word table through
 APB, queues expected reads and compares them in a monitor process.
 Assumes the zero-wait APB slave and commit timing of the decoder.
*/
`timescale 1ns/1ns
module tb_top;
    logic CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic TMR_PRESCALE_CLEAR, WDT_CLEAR, STANDBY;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, seed, r, s;
    logic [4:0] idx;
    logic [13:0] word;
    logic [7:0] operand;
    logic [65:0] expq [$];
    logic [65:0] e;
    int mismatches, comparisons, pulses, wdt_pulses;
    // Per row: accumulator in, accumulator out, status flags, result, two-cycle
    localparam logic [38:0] EXP [0:23] = '{{8'h0F, 8'h0F, 5'h18, 17'h0A0FF, 1'b0},
        {8'hF0, 8'h00, 5'h1C, 17'h10000, 1'b0}, {8'h3C, 8'h00, 5'h1C, 17'h10000, 1'b0},
        {8'h55, 8'h55, 5'h1D, 17'h0A102, 1'b0}, {8'h00, 8'h81, 5'h1C, 17'h10081, 1'b0},
        {8'h81, 8'h81, 5'h1C, 17'h0A300, 1'b1}, {8'h81, 8'h11, 5'h1C, 17'h10011, 1'b0},
        {8'h11, 8'h11, 5'h1C, 17'h0A57F, 1'b0}, {8'h11, 8'h11, 5'h1C, 17'h0A601, 1'b0},
        {8'h11, 8'h11, 5'h1C, 17'h00000, 1'b1}, {8'h11, 8'h11, 5'h1C, 17'h00000, 1'b1},
        {8'h11, 8'h11, 5'h1C, 17'h00000, 1'b0}, {8'h50, 8'h5A, 5'h18, 17'h1005A, 1'b0},
        {8'h5A, 8'h00, 5'h1C, 17'h10000, 1'b0}, {8'h01, 8'h0F, 5'h19, 17'h1000F, 1'b0},
        {8'h0F, 8'h77, 5'h19, 17'h10077, 1'b0}, {8'h77, 8'h99, 5'h19, 17'h10099, 1'b1},
        {8'h99, 8'h99, 5'h19, 17'h00000, 1'b0}, {8'h99, 8'h99, 5'h19, 17'h00000, 1'b0},
        {8'hFF, 8'h00, 5'h1F, 17'h10000, 1'b0}, {8'h00, 8'h00, 5'h1F, 17'h00000, 1'b0},
        {8'h00, 8'h00, 5'h1F, 17'h00000, 1'b1}, {8'h00, 8'h00, 5'h17, 17'h00000, 1'b0},
        {8'h00, 8'h00, 5'h17, 17'h08101, 1'b0}};

    insn_decoder i_dut (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .TMR_PRESCALE_CLEAR(TMR_PRESCALE_CLEAR), .WDT_CLEAR(WDT_CLEAR), .STANDBY(STANDBY));
    prog_mem i_mem (.addr(idx), .word(word), .operand(operand));

    // Clock of 20 ns period
    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One APB transfer, held until PREADY is sampled high or 20 access clocks have passed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1)
        begin
            mismatches++;
            give_verdict();
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] exp, input logic [32:0] mask);
        expq.push_back({mask, exp});
        apb(1'b0, a, 32'h0);
    endtask

    // Runs one table row and checks timing and results
    task automatic run(input int i);
        logic [38:0] x;
        x = EXP[i];
        idx = 5'(i);
        @(posedge CLK);
        apb(1'b1, 8'h08, {24'h0, x[38:31]});
        apb(1'b1, 8'h04, {24'h0, operand});
        apb(1'b1, 8'h00, {18'h0, word});
        repeat (5) @(posedge CLK);
        rd(8'h0C, {27'h0, x[0], 5'h0}, 33'h20);
        repeat (8) @(posedge CLK);
        rd(8'h08, {25'h0, x[30:23]}, 33'hFF);
        rd(8'h0C, {28'h0, x[22:18]}, 33'h1F);
        rd(8'h10, {16'h0, x[17:1]}, x[17] ? 33'h180FF : (x[16] ? 33'h1FFFF : 33'h0));
    endtask

    function automatic logic [31:0] xorshift(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // Monitor: each completed read is compared with the oldest note
    always @(posedge CLK)
    begin
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
        begin
            e = (expq.size() > 0) ? expq.pop_front() : {33'h1FFFFFFFF, 33'h1FFFFFFFF};
            check("read", {PSLVERR, PRDATA} & e[65:33], e[32:0]);
        end
        if (TMR_PRESCALE_CLEAR === 1'b1)
            pulses++;
        if (WDT_CLEAR === 1'b1)
            wdt_pulses++;
    end

    // Main sequence
    initial
    begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, RESETN, idx} = '0;
        seed = 32'h00000054;
        repeat (8) @(posedge CLK);
        RESETN <= 1'b1;
        rd(8'h0C, 33'h18, 33'hFF);
        rd(8'h20, 33'h100000000, 33'h1FFFFFFFF);
        apb(1'b1, 8'h1C, 32'h3C);
        for (int i = 0; i < 23; i++)
            run(i);
        check("standby", {32'h0, STANDBY}, 33'h1);
        check("wdt", 33'(wdt_pulses), 33'h2);
        rd(8'h14, 33'h124, 33'h7FF);
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, 8'h18, 32'(k));
            run(23);
            check("prescale", 33'(pulses), 33'(k));
        end
        check("standby", {32'h0, STANDBY}, 33'h0);
        for (int k = 0; k < 4; k++)
        begin
            seed = xorshift(seed);
            r = seed;
            seed = xorshift(seed);
            s = seed;
            apb(1'b1, 8'h08, {24'h0, r[7:0]});
            apb(1'b1, 8'h04, {24'h0, s[7:0]});
            apb(1'b1, 8'h00, 32'h0620);
            repeat (12) @(posedge CLK);
            rd(8'h08, {25'h0, r[7:0] ^ s[7:0]}, 33'hFF);
            rd(8'h0C, {30'h0, (r[7:0] == s[7:0]), 2'h0}, 33'h04);
        end
        give_verdict();
    end
endmodule
